// >>> core/wdt_unit.sv
// watchdog timer unit: mode decode, sleep handling, flags, registers
// Function
// - timeout while awake resets the system
// - time base is the low-frequency oscillator tick; periods are base multiples
// - mode 11 keeps the watchdog active always, sleep included
// - mode 10 active while awake, off in sleep
// - mode 01 follows the software enable bit
// - mode 00 always off; software enable ignored outside mode 01
// - period code gives 2^(5+code) oscillator cycles, up to code 10010
// - codes 10011 to 11111 act as the minimum 1:32 period
// - reset loads period code 01011 and clears software enable
// - count cleared on reset, clear, sleep edges, osc fail, disable, start-up
// - sleep entry clears, then counting resumes if still active
// - wake clears; held clear while start-up delay runs
// - timeout in sleep wakes instead of resetting, and sets flags
// - internal oscillator divider change leaves the count alone
// - control bits 7:6 read zero, period in 5:1, enable in 0
`timescale 1ns/1ns
`include "wdt_regs.svh"
module wdt_unit
  import wdt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  input  wire logic        lfosc_tick_i,
  input  wire logic [1:0]  watchdog_mode_config_i,
  input  wire logic        sleep_i,
  input  wire logic        clear_instr_i,
  input  wire logic        osc_fail_i,
  input  wire logic        ost_running_i,
  output logic             sys_reset_o,
  output logic             wake_o,
  output logic             expiry_flag_o,
  output logic             sleep_entered_flag_o,
  output logic             irq_o
);

  wdt_state_t            st;
  wdt_state_t            next_st;
  wdt_req_t              req;
  logic [31:0]           rdata;
  logic [`WDT_CNT_W-1:0] count;
  logic                  expire;
  logic                  active;
  logic                  entry;
  logic                  exit_sleep;
  logic                  clear;
  logic [1:0]            ev_set;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  function automatic logic mode_active(input logic [1:0] mode,
                                       input logic       swen,
                                       input logic       asleep);
    case (mode)
      `WDT_MODE_ON:  mode_active = 1'b1;
      `WDT_MODE_AWK: mode_active = ~asleep;
      `WDT_MODE_SW:  mode_active = swen;
      default:       mode_active = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // bus front end and counter
  // ----------------------------------------
  wdt_wb_slave u_slave (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cyc_i   (cyc_i),
    .stb_i   (stb_i),
    .we_i    (we_i),
    .adr_i   (adr_i),
    .sel_i   (sel_i),
    .dat_i   (dat_i),
    .rdata_i (rdata),
    .ack_o   (ack_o),
    .dat_o   (dat_o),
    .req_o   (req)
  );

  // only the oscillator tick advances the count, so divider changes cannot
  wdt_counter u_counter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (lfosc_tick_i),
    .clear_i  (clear),
    .ps_i     (st.ps),
    .count_o  (count),
    .expire_o (expire)
  );

  // ----------------------------------------
  // clear sources
  // ----------------------------------------
  always_comb begin
    active     = mode_active(watchdog_mode_config_i, st.swen, sleep_i);
    entry      = sleep_i & ~st.sleep_q;
    exit_sleep = ~sleep_i & st.sleep_q;
    // start-up delay input held high keeps the count clear
    clear      = clear_instr_i | entry | exit_sleep | osc_fail_i
               | ~active | ost_running_i;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st          = st;
    next_st.sleep_q  = sleep_i;
    next_st.rst_out  = expire & ~sleep_i;
    next_st.wake_out = expire & sleep_i;
    ev_set           = '0;
    ev_set[`WDT_EV_RESET] = expire & ~sleep_i;
    ev_set[`WDT_EV_WAKE]  = expire & sleep_i;
    // clears first so a same-cycle set wins
    if (clear_instr_i) begin
      next_st.expiry     = 1'b0;
      next_st.sleep_flag = 1'b0;
    end
    if (entry) begin
      next_st.sleep_flag = 1'b1;
    end
    if (expire) begin
      next_st.expiry = 1'b1;
      if (sleep_i) begin
        next_st.sleep_flag = 1'b1;
      end
    end
    if (req.valid) begin
      case (req.adr)
        `WDT_ADR_CTRL: begin
          next_st.ps   = req.wdata[`WDT_PS_MSB:`WDT_PS_LSB];
          next_st.swen = req.wdata[`WDT_SWEN_BIT];
        end
        `WDT_ADR_STAT: next_st.ev = st.ev & ~req.wdata[1:0];
        `WDT_ADR_MASK: next_st.mask = req.wdata[1:0];
        default: ;
      endcase
    end
    next_st.ev  = next_st.ev | ev_set;
    next_st.irq = |(next_st.ev & next_st.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st      <= '0;
      st.ps   <= `WDT_PS_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // read mux; upper control bits stay zero
  // ----------------------------------------
  always_comb begin
    rdata = '0;
    case (adr_i)
      `WDT_ADR_CTRL:  rdata[5:0] = {st.ps, st.swen};
      `WDT_ADR_STAT:  rdata[1:0] = st.ev;
      `WDT_ADR_MASK:  rdata[1:0] = st.mask;
      `WDT_ADR_FLAGS: rdata[2:0] = {active, st.sleep_flag, st.expiry};
      `WDT_ADR_COUNT: rdata[`WDT_CNT_W-1:0] = count;
      default:        rdata = '0;
    endcase
  end

  assign sys_reset_o          = st.rst_out;
  assign wake_o               = st.wake_out;
  assign expiry_flag_o        = st.expiry;
  assign sleep_entered_flag_o = st.sleep_flag;
  assign irq_o                = st.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_timeout_awake;
    expire && !sleep_i;
  endsequence

  sequence s_timeout_asleep;
    expire && sleep_i;
  endsequence

  sequence s_enter_on;
    entry && watchdog_mode_config_i == `WDT_MODE_ON;
  endsequence

  sequence s_first_tick;
    lfosc_tick_i && !clear;
  endsequence

  a_reset_awake: assert property (s_timeout_awake |=> sys_reset_o && !wake_o)
    else $error("awake timeout gave no reset");
  a_wake_sleep: assert property (s_timeout_asleep |=> wake_o && !sys_reset_o
    && expiry_flag_o && sleep_entered_flag_o) else $error("sleep timeout handled wrong");
  a_mode_on: assert property (watchdog_mode_config_i == `WDT_MODE_ON |-> active)
    else $error("mode 11 not active");
  a_mode_awake: assert property (watchdog_mode_config_i == `WDT_MODE_AWK
    |-> active == !sleep_i) else $error("mode 10 wrong");
  a_mode_sw: assert property (watchdog_mode_config_i == `WDT_MODE_SW
    |-> active == st.swen) else $error("mode 01 ignores enable");
  a_mode_off: assert property (watchdog_mode_config_i == `WDT_MODE_OFF
    |-> !active) else $error("mode 00 active");
  a_clear_count: assert property (clear |=> count == '0)
    else $error("count not cleared");
  a_sleep_resume: assert property (s_enter_on ##1 s_first_tick |=>
    count == `WDT_CNT_W'(1)) else $error("count not resumed after sleep entry");
  a_ost_hold: assert property (ost_running_i [*2] |=> count == '0)
    else $error("count moved during start-up delay");
  a_reset_vals: assert property ($fell(rst_i) |-> st.ps == `WDT_PS_RST
    && !st.swen) else $error("control reset value wrong");
  a_flag_clear: assert property (clear_instr_i && !expire |=> !expiry_flag_o)
    else $error("clear did not drop expiry flag");
  a_ctrl_high: assert property (adr_i == `WDT_ADR_CTRL |-> rdata[7:6] == 2'b00)
    else $error("control bits 7:6 not zero");

endmodule

// >>> core/wdt_regs.svh
// register map, field positions and reset values of the watchdog unit
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define WDT_ADR_CTRL  8'h00
`define WDT_ADR_STAT  8'h04
`define WDT_ADR_MASK  8'h08
`define WDT_ADR_FLAGS 8'h0C
`define WDT_ADR_COUNT 8'h10

// ----------------------------------------
// control fields and reset value
// ----------------------------------------
`define WDT_SWEN_BIT  0
`define WDT_PS_LSB    1
`define WDT_PS_MSB    5
`define WDT_PS_RST    5'h0B
`define WDT_PS_MAX    5'h12
`define WDT_BASE_LOG2 5'h05

// ----------------------------------------
// mode codes, event bits, widths
// ----------------------------------------
`define WDT_MODE_OFF  2'h0
`define WDT_MODE_SW   2'h1
`define WDT_MODE_AWK  2'h2
`define WDT_MODE_ON   2'h3
`define WDT_EV_RESET  0
`define WDT_EV_WAKE   1
`define WDT_CNT_W     24

`endif

// >>> core/wdt_pkg.sv
// shared types of the watchdog unit
package wdt_pkg;

  // ----------------------------------------
  // bus request handed to the register file
  // ----------------------------------------
  typedef struct packed {
    logic        valid;
    logic [7:0]  adr;
    logic [31:0] wdata;
  } wdt_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wdt_wb_state_t;

  // ----------------------------------------
  // main state
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] ps;
    logic       swen;
    logic [1:0] ev;
    logic [1:0] mask;
    logic       expiry;
    logic       sleep_flag;
    logic       sleep_q;
    logic       rst_out;
    logic       wake_out;
    logic       irq;
  } wdt_state_t;

endpackage

// >>> core/wdt_wb_slave.sv
// classic wishbone slave front end with registered ack and read data
`timescale 1ns/1ns
module wdt_wb_slave
  import wdt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [31:0] rdata_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  output wdt_req_t         req_o
);

  wdt_wb_state_t st;
  wdt_wb_state_t next_st;

  // ----------------------------------------
  // ack one cycle after the request, dropped after one cycle
  // ----------------------------------------
  always_comb begin
    next_st     = st;
    next_st.ack = cyc_i & stb_i & ~st.ack;
    if (next_st.ack) begin
      next_st.dat = rdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // write lands on the edge the master samples ack
  assign req_o.valid = cyc_i & stb_i & we_i & st.ack & sel_i[0];
  assign req_o.adr   = adr_i;
  assign req_o.wdata = dat_i;
  assign ack_o       = st.ack;
  assign dat_o       = st.dat;

endmodule

// >>> core/wdt_counter.sv
// prescaled count of low-frequency oscillator cycles
`timescale 1ns/1ns
`include "wdt_regs.svh"
module wdt_counter
  import wdt_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 tick_i,
  input  wire logic                 clear_i,
  input  wire logic [4:0]           ps_i,
  output logic [`WDT_CNT_W-1:0]     count_o,
  output logic                      expire_o
);

  logic [`WDT_CNT_W-1:0] count;
  logic [`WDT_CNT_W-1:0] next_count;
  logic [`WDT_CNT_W-1:0] lim;

  // ----------------------------------------
  // last count of the period: 2^(5+code)-1
  // ----------------------------------------
  function automatic logic [`WDT_CNT_W-1:0] last_count(input logic [4:0] code);
    logic [4:0] sh;
    sh = (code > `WDT_PS_MAX) ? 5'h00 : code;
    last_count = (`WDT_CNT_W'(1) << (sh + `WDT_BASE_LOG2)) - `WDT_CNT_W'(1);
  endfunction

  // >= so a shorter period chosen mid-count still ends
  always_comb begin
    lim        = last_count(ps_i);
    expire_o   = tick_i & ~clear_i & (count >= lim);
    next_count = count;
    if (clear_i || expire_o) begin
      next_count = '0;
    end else if (tick_i) begin
      next_count = count + `WDT_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign count_o = count;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reserved_min: assert property (tick_i && !clear_i && ps_i > `WDT_PS_MAX
    && count == `WDT_CNT_W'(31) |-> expire_o) else $error("reserved code not minimum");
  a_two_sec: assert property (ps_i == `WDT_PS_RST && tick_i && !clear_i
    && count == `WDT_CNT_W'(65535) |-> expire_o) else $error("1:65536 period wrong");
  a_no_early: assert property (count < `WDT_CNT_W'(31) |-> !expire_o)
    else $error("expiry before minimum period");

endmodule

// >>> verif/wdt_unit_tb_top.sv
// self-checking testbench of the watchdog unit
`timescale 1ns/1ns
`include "wdt_regs.svh"
module wdt_unit_tb_top;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic        lfosc_tick_i, sleep_i, clear_instr_i, osc_fail_i, ost_running_i;
  logic [1:0]  mode;
  logic        sys_reset_o, wake_o, expiry_flag_o, sleep_entered_flag_o, irq_o;
  logic        got_r, got_w;
  int          err_count, checks_done;
  logic [4:0]  run_codes [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1F};

  wdt_unit uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
    .lfosc_tick_i(lfosc_tick_i), .watchdog_mode_config_i(mode), .sleep_i(sleep_i),
    .clear_instr_i(clear_instr_i), .osc_fail_i(osc_fail_i),
    .ost_running_i(ost_running_i), .sys_reset_o(sys_reset_o), .wake_o(wake_o),
    .expiry_flag_o(expiry_flag_o), .sleep_entered_flag_o(sleep_entered_flag_o),
    .irq_o(irq_o));

  always #20 clk_i = ~clk_i;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // classic single cycle; waits for ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    if (ack_o !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask

  // n consecutive oscillator ticks, one per clock
  task automatic ticks(input int n);
    lfosc_tick_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    lfosc_tick_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic clr();
    clear_instr_i <= 1'b1;
    @(posedge clk_i);
    clear_instr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_event();
    got_r = 1'b0;
    got_w = 1'b0;
    repeat (8) begin
      @(posedge clk_i);
      if (sys_reset_o === 1'b1) got_r = 1'b1;
      if (wake_o === 1'b1) got_w = 1'b1;
    end
  endtask

  // final tick, then watch at once: the pulse stands only one cycle
  task automatic tick_watch();
    lfosc_tick_i <= 1'b1;
    @(posedge clk_i);
    lfosc_tick_i <= 1'b0;
    wait_event();
  endtask

  // one full period in mode 11, awake; reserved codes fold to 32
  task automatic run_period(input logic [4:0] code);
    int p;
    p = (code > `WDT_PS_MAX) ? 32 : (1 << (5 + code));
    wr(`WDT_ADR_CTRL, {26'h0, code, 1'b0});
    clr();
    ticks(p - 1);
    rd(`WDT_ADR_COUNT);
    check("count", q, 32'(p - 1));
    check("early reset", {31'h0, sys_reset_o}, 32'h0000_0000);
    tick_watch();
    check("reset pulse", {30'h0, got_r, got_w}, 32'h0000_0002);
    check("expiry flag", {31'h0, expiry_flag_o}, 32'h0000_0001);
    clr();
    check("expiry clear", {31'h0, expiry_flag_o}, 32'h0000_0000);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk_i = 0; rst_i = 1; cyc_i = 0; stb_i = 0; we_i = 0; adr_i = 0; sel_i = 0;
    dat_i = 0; lfosc_tick_i = 0; sleep_i = 0; clear_instr_i = 0; osc_fail_i = 0;
    ost_running_i = 0; mode = 2'h3; err_count = 0; checks_done = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`WDT_ADR_CTRL);
    check("ctrl reset", q, 32'h0000_0016);
    rd(`WDT_ADR_COUNT);
    check("count reset", q, 32'h0000_0000);
    wr(`WDT_ADR_CTRL, 32'h0000_00FF);
    rd(`WDT_ADR_CTRL);
    check("ctrl bits", q, 32'h0000_003F);
    wb(1'b1, `WDT_ADR_CTRL, 32'h0000_0000, 4'hE, q);
    rd(`WDT_ADR_CTRL);
    check("ctrl no sel", q, 32'h0000_003F);
    wr(8'h20, 32'h0000_00FF);
    rd(8'h20);
    check("unmapped", q, 32'h0000_0000);
    // mode 11 ignores enable bit; codes incl. reserved ones
    foreach (run_codes[i]) run_period(run_codes[i]);
    // sticky status, mask and level interrupt
    rd(`WDT_ADR_STAT);
    check("status", q, 32'h0000_0001);
    check("irq masked", {31'h0, irq_o}, 32'h0000_0000);
    wr(`WDT_ADR_MASK, 32'h0000_0001);
    check("irq", {31'h0, irq_o}, 32'h0000_0001);
    wr(`WDT_ADR_STAT, 32'h0000_0001);
    check("irq cleared", {31'h0, irq_o}, 32'h0000_0000);
    // sleep in mode 11: cleared on entry, wakes instead of resetting
    wr(`WDT_ADR_CTRL, 32'h0000_0000);
    ticks(5);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    ticks(3);
    rd(`WDT_ADR_COUNT);
    check("sleep count", q, 32'h0000_0003);
    check("sleep flag", {31'h0, sleep_entered_flag_o}, 32'h0000_0001);
    ticks(28);
    tick_watch();
    check("wake pulse", {30'h0, got_r, got_w}, 32'h0000_0001);
    rd(`WDT_ADR_STAT);
    check("wake status", q, 32'h0000_0002);
    check("irq bit1 masked", {31'h0, irq_o}, 32'h0000_0000);
    // wake with start-up delay running holds the count clear
    ost_running_i <= 1'b1;
    sleep_i <= 1'b0;
    ticks(40);
    rd(`WDT_ADR_COUNT);
    check("ost hold", q, 32'h0000_0000);
    ost_running_i <= 1'b0;
    ticks(2);
    rd(`WDT_ADR_COUNT);
    check("after ost", q, 32'h0000_0002);
    osc_fail_i <= 1'b1;
    ticks(40);
    rd(`WDT_ADR_COUNT);
    check("osc fail", q, 32'h0000_0000);
    osc_fail_i <= 1'b0;
    // mode 10: awake counts, asleep stays clear
    mode <= 2'h2;
    clr();
    ticks(4);
    rd(`WDT_ADR_COUNT);
    check("mode10 awake", q, 32'h0000_0004);
    sleep_i <= 1'b1;
    ticks(40);
    rd(`WDT_ADR_COUNT);
    check("mode10 sleep", q, 32'h0000_0000);
    sleep_i <= 1'b0;
    // mode 01 follows the enable bit, asleep or not
    mode <= 2'h1;
    wr(`WDT_ADR_CTRL, 32'h0000_0001);
    clr();
    ticks(5);
    rd(`WDT_ADR_COUNT);
    check("mode01 on", q, 32'h0000_0005);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    ticks(5);
    rd(`WDT_ADR_COUNT);
    check("mode01 sleep", q, 32'h0000_0005);
    sleep_i <= 1'b0;
    wr(`WDT_ADR_CTRL, 32'h0000_0000);
    ticks(5);
    rd(`WDT_ADR_COUNT);
    check("mode01 off", q, 32'h0000_0000);
    // mode 00 ignores the enable bit
    wr(`WDT_ADR_CTRL, 32'h0000_0001);
    mode <= 2'h0;
    ticks(40);
    rd(`WDT_ADR_COUNT);
    check("mode00", q, 32'h0000_0000);
    wrap_up();
  end
endmodule
